// ===== rtl/fcap_top.sv
// Command framing, clock-mode pick and power-up state of the flash host port
`timescale 1ns/100ps
module fcap_top #(
  parameter int PUW_CYCLES = fcap_pkg::PUW_CYC
) (
  input wire logic REF_CLK_I,
  input wire logic RESETN_I,
  input wire logic CE_I,
  input wire logic SEL_N_I,
  input wire logic SER_CLK_I,
  input wire logic SER_IN_I,
  output logic SER_OUT_O,
  output logic SER_OUT_OE_O,
  input wire logic BYTE_CLK_I,
  input wire logic [7:0] BYTE_PORT_LINES_I,
  output logic [7:0] BYTE_PORT_LINES_O,
  output logic BYTE_PORT_LINES_OE_O,
  input wire logic CORE_BUSY_I,
  output logic CMD_VALID_O,
  output logic [7:0] CMD_OPCODE_O,
  output logic [fcap_pkg::PAGE_W-1:0] CMD_PAGE_O,
  output logic [fcap_pkg::BYTE_W-1:0] CMD_BYTE_O,
  output logic [fcap_pkg::DUM_W-1:0] CMD_DUMMY_O,
  output logic DATA_VALID_O,
  output logic [7:0] DATA_O,
  output logic CLK_MODE3_O,
  output logic BYTE_IF_O,
  output logic STANDBY_O,
  output logic WRITE_READY_O
);
  logic s_sel_n, s_sck, s_si, s_bclk;
  logic [7:0] s_bio;
  logic prev_sel_n, prev_sck, prev_bclk;
  logic sel_fall, sck_rise, sck_fall, bclk_rise;
  logic use_ser, use_byt, bit_ev, byte_ev, in_opc;
  logic [7:0] byte_val, dec_op, status;
  logic [fcap_pkg::ADDR_W-1:0] dec_addr;
  logic dec_has_addr;
  logic [fcap_pkg::PAGE_W-1:0] dec_page;
  logic [fcap_pkg::BYTE_W-1:0] dec_byte;
  logic [fcap_pkg::DUM_W-1:0] dec_dummy;
  fcap_pkg::fcap_state_t state, next_state;
  logic mode3, next_mode3, byte_if, next_byte_if;
  logic [2:0] bit_cnt, next_bit_cnt;
  logic [7:0] shreg, next_shreg, opcode, next_opcode;
  logic [1:0] addr_cnt, next_addr_cnt;
  logic [fcap_pkg::ADDR_W-1:0] addr, next_addr;
  logic [fcap_pkg::DUM_W-1:0] dummy_left, next_dummy_left;
  logic [7:0] out_sh, next_out_sh;
  logic ser_out, next_ser_out;
  logic cmd_valid, next_cmd_valid;
  logic [fcap_pkg::PAGE_W-1:0] cmd_page, next_cmd_page;
  logic [fcap_pkg::BYTE_W-1:0] cmd_byte, next_cmd_byte;
  logic [fcap_pkg::DUM_W-1:0] cmd_dummy, next_cmd_dummy;
  logic data_valid, next_data_valid;
  logic [7:0] data, next_data, byte_out, next_byte_out;
  logic [31:0] puw_cnt, next_puw_cnt;
  logic write_ready, next_write_ready;
  logic seen_frame, next_seen_frame;
  logic drive_on;

  fcap_sync #(.W(12)) u_sync (
    .clk_i(REF_CLK_I),
    .rst_n_i(RESETN_I),
    .en_i(CE_I),
    .d_i({SEL_N_I, SER_CLK_I, SER_IN_I, BYTE_CLK_I, BYTE_PORT_LINES_I}),
    .q_o({s_sel_n, s_sck, s_si, s_bclk, s_bio})
  );

  assign sel_fall = prev_sel_n & ~s_sel_n;
  assign sck_rise = ~prev_sck & s_sck;
  assign sck_fall = prev_sck & ~s_sck;
  assign bclk_rise = ~prev_bclk & s_bclk;

  assign in_opc = (state == fcap_pkg::ST_SEL) || (state == fcap_pkg::ST_OPC);
  assign use_ser = (state == fcap_pkg::ST_SEL) ? sck_rise : ~byte_if;
  assign use_byt = (state == fcap_pkg::ST_SEL) ? (bclk_rise & ~sck_rise) : byte_if;
  assign bit_ev = use_ser & sck_rise & ~s_sel_n;
  assign byte_ev = (bit_ev & (bit_cnt == 3'h7)) | (use_byt & bclk_rise & ~s_sel_n);
  assign byte_val = use_byt ? s_bio : {shreg[6:0], s_si};
  assign dec_op = in_opc ? byte_val : opcode;
  assign dec_addr = {addr[15:0], byte_val};
  assign status = {~CORE_BUSY_I, 7'h00};

  fcap_addr_split u_split (
    .op_i(dec_op),
    .addr_i(dec_addr),
    .byte_if_i(next_byte_if),
    .has_addr_o(dec_has_addr),
    .page_o(dec_page),
    .byte_o(dec_byte),
    .dummy_o(dec_dummy)
  );

  always_comb
  begin
    next_state = state;
    next_mode3 = mode3;
    next_byte_if = byte_if;
    next_bit_cnt = bit_cnt;
    next_shreg = shreg;
    next_opcode = opcode;
    next_addr_cnt = addr_cnt;
    next_addr = addr;
    next_dummy_left = dummy_left;
    next_out_sh = out_sh;
    next_ser_out = ser_out;
    next_cmd_valid = 1'b0;
    next_cmd_page = cmd_page;
    next_cmd_byte = cmd_byte;
    next_cmd_dummy = cmd_dummy;
    next_data_valid = 1'b0;
    next_data = data;
    next_byte_out = status;
    next_seen_frame = seen_frame | sel_fall;
    if (state == fcap_pkg::ST_SEL && (bit_ev || byte_ev))
      next_byte_if = use_byt;
    if (bit_ev)
    begin
      next_shreg = byte_val;
      next_bit_cnt = bit_cnt + 3'h1;
    end
    case (state)
      fcap_pkg::ST_IDLE:
      begin
        // only a select fall opens a frame
        if (sel_fall)
        begin
          next_mode3 = s_sck;
          next_bit_cnt = 3'h0;
          next_addr_cnt = 2'h0;
          next_state = fcap_pkg::ST_SEL;
        end
      end
      fcap_pkg::ST_SEL, fcap_pkg::ST_OPC:
      begin
        if (bit_ev && !byte_ev)
          next_state = fcap_pkg::ST_OPC;
        if (byte_ev)
        begin
          next_opcode = byte_val;
          if (dec_has_addr)
            next_state = fcap_pkg::ST_ADDR;
          else
          begin
            next_cmd_valid = 1'b1;
            next_cmd_page = '0;
            next_cmd_byte = '0;
            next_cmd_dummy = dec_dummy;
            next_dummy_left = dec_dummy;
            next_out_sh = status;
            next_state = (dec_dummy == fcap_pkg::DUM_NONE) ? fcap_pkg::ST_DATA :
                         fcap_pkg::ST_DUMMY;
          end
        end
      end
      fcap_pkg::ST_ADDR:
      begin
        if (byte_ev)
        begin
          next_addr = dec_addr;
          next_addr_cnt = addr_cnt + 2'h1;
          if (addr_cnt == fcap_pkg::ADDR_LAST)
          begin
            next_cmd_valid = 1'b1;
            next_cmd_page = dec_page;
            next_cmd_byte = dec_byte;
            next_cmd_dummy = dec_dummy;
            next_dummy_left = dec_dummy;
            next_state = (dec_dummy == fcap_pkg::DUM_NONE) ? fcap_pkg::ST_DATA :
                         fcap_pkg::ST_DUMMY;
          end
        end
      end
      fcap_pkg::ST_DUMMY:
      begin
        if (byte_ev)
        begin
          next_dummy_left = dummy_left - fcap_pkg::DUM_ONE;
          if (dummy_left == fcap_pkg::DUM_ONE)
          begin
            next_out_sh = status;
            next_state = fcap_pkg::ST_DATA;
          end
        end
      end
      fcap_pkg::ST_DATA:
      begin
        if (byte_ev)
        begin
          next_data_valid = 1'b1;
          next_data = byte_val;
        end
        if (sck_fall && !byte_if)
        begin
          next_ser_out = out_sh[fcap_pkg::STAT_RDY_BIT];
          next_out_sh = {out_sh[6:0], out_sh[7]};
        end
      end
      default:
        next_state = fcap_pkg::ST_IDLE;
    endcase
    // Deselect aborts any frame
    if (s_sel_n && state != fcap_pkg::ST_IDLE)
      next_state = fcap_pkg::ST_IDLE;
  end

  always_comb
  begin
    next_puw_cnt = puw_cnt;
    next_write_ready = write_ready;
    if (!write_ready)
    begin
      next_puw_cnt = puw_cnt + 32'h1;
      if (puw_cnt == 32'(PUW_CYCLES - 1))
        next_write_ready = 1'b1;
    end
  end

  always_ff @(posedge REF_CLK_I or negedge RESETN_I)
  begin
    if (!RESETN_I)
    begin
      prev_sel_n <= 1'b0;
      prev_sck <= 1'b1;
      prev_bclk <= 1'b0;
      state <= fcap_pkg::ST_IDLE;
      mode3 <= fcap_pkg::MODE_RESET;
      byte_if <= 1'b0;
      bit_cnt <= 3'h0;
      shreg <= 8'h00;
      opcode <= 8'h00;
      addr_cnt <= 2'h0;
      addr <= '0;
      dummy_left <= '0;
      out_sh <= 8'h00;
      ser_out <= 1'b0;
      cmd_valid <= 1'b0;
      cmd_page <= '0;
      cmd_byte <= '0;
      cmd_dummy <= '0;
      data_valid <= 1'b0;
      data <= 8'h00;
      byte_out <= 8'h00;
      puw_cnt <= 32'h0;
      write_ready <= 1'b0;
      seen_frame <= 1'b0;
    end
    else if (CE_I)
    begin
      prev_sel_n <= s_sel_n;
      prev_sck <= s_sck;
      prev_bclk <= s_bclk;
      state <= next_state;
      mode3 <= next_mode3;
      byte_if <= next_byte_if;
      bit_cnt <= next_bit_cnt;
      shreg <= next_shreg;
      opcode <= next_opcode;
      addr_cnt <= next_addr_cnt;
      addr <= next_addr;
      dummy_left <= next_dummy_left;
      out_sh <= next_out_sh;
      ser_out <= next_ser_out;
      cmd_valid <= next_cmd_valid;
      cmd_page <= next_cmd_page;
      cmd_byte <= next_cmd_byte;
      cmd_dummy <= next_cmd_dummy;
      data_valid <= next_data_valid;
      data <= next_data;
      byte_out <= next_byte_out;
      puw_cnt <= next_puw_cnt;
      write_ready <= next_write_ready;
      seen_frame <= next_seen_frame;
    end
  end

  // drive only during status data phase
  assign drive_on = (state == fcap_pkg::ST_DATA) && (opcode == fcap_pkg::OPC_STATUS) && !s_sel_n;
  assign SER_OUT_OE_O = drive_on & ~byte_if;
  assign BYTE_PORT_LINES_OE_O = drive_on & byte_if;
  assign SER_OUT_O = ser_out;
  assign BYTE_PORT_LINES_O = byte_out;
  assign CMD_VALID_O = cmd_valid;
  assign CMD_OPCODE_O = opcode;
  assign CMD_PAGE_O = cmd_page;
  assign CMD_BYTE_O = cmd_byte;
  assign CMD_DUMMY_O = cmd_dummy;
  assign DATA_VALID_O = data_valid;
  assign DATA_O = data;
  assign CLK_MODE3_O = mode3;
  assign BYTE_IF_O = byte_if;
  assign STANDBY_O = (state == fcap_pkg::ST_IDLE);
  assign WRITE_READY_O = write_ready;

  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (!RESETN_I);

  chk_mode_default: assert property (!seen_frame |-> mode3)
    else $error("mode not 3 before first frame");
  chk_hiz_idle: assert property (state == fcap_pkg::ST_IDLE |-> !SER_OUT_OE_O && !BYTE_PORT_LINES_OE_O)
    else $error("output driven while idle");
  chk_fall_needed: assert property (state == fcap_pkg::ST_IDLE && !sel_fall && CE_I |=> state == fcap_pkg::ST_IDLE)
    else $error("frame opened without select fall");
  chk_deselect_abort: assert property (s_sel_n && state != fcap_pkg::ST_IDLE && CE_I |=> state == fcap_pkg::ST_IDLE)
    else $error("frame not closed by deselect");
  chk_mode_pick: assert property (state == fcap_pkg::ST_IDLE && sel_fall && CE_I |=> mode3 == $past(s_sck))
    else $error("mode not taken from clock idle level");
  chk_por_quiet: assert property (@(posedge REF_CLK_I) disable iff (1'b0) !RESETN_I && !$past(RESETN_I) |-> !CMD_VALID_O && !DATA_VALID_O && STANDBY_O)
    else $error("activity during power-on reset");
  chk_standby_start: assert property (!seen_frame |-> STANDBY_O && !CMD_VALID_O)
    else $error("not in standby after power-up");
  chk_page_split: assert property (CMD_VALID_O && CMD_OPCODE_O == fcap_pkg::OPC_PAGE_READ |-> {CMD_PAGE_O, CMD_BYTE_O} == addr)
    else $error("page and byte address split wrong");
  chk_dont_care: assert property (CMD_VALID_O && CMD_OPCODE_O == fcap_pkg::OPC_BYTE_ONLY |-> CMD_PAGE_O == '0)
    else $error("don't-care page bits leaked");
  chk_dummy_cnt: assert property (CMD_VALID_O && CMD_OPCODE_O == fcap_pkg::OPC_CONT_READ |-> CMD_DUMMY_O == (byte_if ? 5'h13 : 5'h04))
    else $error("wrong dummy count");
  chk_dummy_walk: assert property (state == fcap_pkg::ST_DUMMY && byte_ev && dummy_left == 5'h01 && !s_sel_n && CE_I |=> state == fcap_pkg::ST_DATA)
    else $error("data phase not reached after dummies");

  cov_serial_cmd: cover property (CMD_VALID_O && !byte_if);
  cov_byte_cmd: cover property (CMD_VALID_O && byte_if);
  cov_status_drive: cover property (SER_OUT_OE_O ##1 sck_fall);
  cov_mode0: cover property (sel_fall && !s_sck);
endmodule // fcap_top

// ===== rtl/fcap_pkg.sv
// Constants and types for the flash command framing front end
// Overview of operation
// - Serial timing defaults to mode 3 after reset
// - Serial and byte outputs stay undriven until commanded
// - Each command starts only on select falling edge
// - Clock idle level at select fall picks mode
// - Commands ignored while power-on reset is active
// - Device rests in standby after power-up
// - Address bytes hold 13-bit page, 11-bit byte
// - Unused address bits are ignored by device
// - Opcode-specific dummy bytes follow the address
// - Serial clock/input or byte clock/eight lines, shared select
package fcap_pkg;
  localparam int CLK_FREQ_MHZ = 125;
  localparam int T_PUW_MS = 20;
  localparam int PUW_CYC = T_PUW_MS * 1000 * CLK_FREQ_MHZ;
  localparam int PAGE_W = 13;
  localparam int BYTE_W = 11;
  localparam int ADDR_W = 24;
  localparam int DUM_W = 5;
  localparam int PAGE_LSB = 11;
  localparam int STAT_RDY_BIT = 7;
  localparam logic [1:0] ADDR_LAST = 2'h2;
  localparam logic MODE_RESET = 1'b1;
  localparam logic [7:0] OPC_STATUS = 8'hd7;
  localparam logic [7:0] OPC_CONT_READ = 8'he8;
  localparam logic [7:0] OPC_PAGE_READ = 8'hd2;
  localparam logic [7:0] OPC_BUF1_READ = 8'hd4;
  localparam logic [7:0] OPC_BUF2_READ = 8'hd6;
  localparam logic [7:0] OPC_FAST_READ = 8'h0b;
  localparam logic [7:0] OPC_BYTE_ONLY = 8'h87;
  localparam logic [DUM_W-1:0] DUM_CONT_SER = 5'h04;
  localparam logic [DUM_W-1:0] DUM_CONT_BYTE = 5'h13;
  localparam logic [DUM_W-1:0] DUM_ONE = 5'h01;
  localparam logic [DUM_W-1:0] DUM_STAT_BYTE = 5'h02;
  localparam logic [DUM_W-1:0] DUM_NONE = 5'h00;
  typedef enum logic [2:0] {ST_IDLE, ST_SEL, ST_OPC, ST_ADDR, ST_DUMMY, ST_DATA} fcap_state_t;
endpackage

// ===== rtl/fcap_sync.sv
// Two-stage synchroniser for pin inputs
`timescale 1ns/100ps
module fcap_sync #(
  parameter int W = 1
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic en_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta;

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      meta <= '0;
      q_o <= '0;
    end
    else if (en_i)
    begin
      meta <= d_i;
      q_o <= meta;
    end
  end
endmodule // fcap_sync

// ===== rtl/fcap_addr_split.sv
// Opcode to address layout and dummy count decoder
`timescale 1ns/100ps
module fcap_addr_split (
  input wire logic [7:0] op_i,
  input wire logic [fcap_pkg::ADDR_W-1:0] addr_i,
  input wire logic byte_if_i,
  output logic has_addr_o,
  output logic [fcap_pkg::PAGE_W-1:0] page_o,
  output logic [fcap_pkg::BYTE_W-1:0] byte_o,
  output logic [fcap_pkg::DUM_W-1:0] dummy_o
);
  logic [fcap_pkg::PAGE_W-1:0] raw_page;
  logic [fcap_pkg::BYTE_W-1:0] raw_byte;

  assign raw_page = addr_i[fcap_pkg::ADDR_W-1:fcap_pkg::PAGE_LSB];
  assign raw_byte = addr_i[fcap_pkg::BYTE_W-1:0];

  always_comb
  begin
    has_addr_o = 1'b1;
    page_o = raw_page;
    byte_o = raw_byte;
    case (op_i)
      8'h86, 8'h88, 8'h89, 8'h53, 8'h55, 8'h58, 8'h59, 8'h60, 8'h61, 8'h81, 8'h83:
        byte_o = '0;
      8'h87, 8'h84, 8'hd1, 8'hd3, 8'hd4, 8'hd6, 8'h54, 8'h56:
        page_o = '0;
      8'h50:
      begin
        page_o = {raw_page[12:3], 3'h0};
        byte_o = '0;
      end
      8'h7c:
      begin
        page_o = {raw_page[12:8], 8'h00};
        byte_o = '0;
      end
      8'h9f, 8'hb9, 8'hab, 8'hd7:
      begin
        has_addr_o = 1'b0;
        page_o = '0;
        byte_o = '0;
      end
      default:
        has_addr_o = 1'b1;
    endcase
  end

  always_comb
  begin
    case (op_i)
      fcap_pkg::OPC_PAGE_READ, fcap_pkg::OPC_CONT_READ:
        dummy_o = byte_if_i ? fcap_pkg::DUM_CONT_BYTE : fcap_pkg::DUM_CONT_SER;
      fcap_pkg::OPC_BUF1_READ, fcap_pkg::OPC_BUF2_READ, fcap_pkg::OPC_FAST_READ:
        dummy_o = fcap_pkg::DUM_ONE;
      fcap_pkg::OPC_STATUS:
        dummy_o = byte_if_i ? fcap_pkg::DUM_STAT_BYTE : fcap_pkg::DUM_NONE;
      default:
        dummy_o = fcap_pkg::DUM_NONE;
    endcase
  end
endmodule // fcap_addr_split

// ===== bench/fcap_host_model.sv
// Host controller model for the serial and byte-wide link
`timescale 1ns/100ps
module fcap_host_model (
  input wire logic clk_i,
  output logic sel_n_o,
  output logic ser_clk_o,
  output logic ser_in_o,
  output logic byte_clk_o,
  output logic [7:0] byte_lines_o
);
  initial
  begin
    sel_n_o = 1'b1;
    ser_clk_o = 1'b1;
    ser_in_o = 1'b0;
    byte_clk_o = 1'b0;
    byte_lines_o = 8'h00;
  end
  // Half of the 160 ns link period
  task automatic half();
    repeat (10) @(negedge clk_i);
  endtask
  task automatic open_frame(input logic mode3);
    ser_clk_o = mode3;
    half();
    sel_n_o = 1'b0;
    half();
  endtask
  task automatic ser_byte(input logic [7:0] b);
    for (int i = 7; i >= 0; i--)
    begin
      ser_clk_o = 1'b0;
      ser_in_o = b[i];
      half();
      ser_clk_o = 1'b1;
      half();
    end
  endtask
  task automatic ser_low();
    ser_clk_o = 1'b0;
    half();
  endtask
  task automatic par_byte(input logic [7:0] b);
    byte_clk_o = 1'b0;
    byte_lines_o = b;
    half();
    byte_clk_o = 1'b1;
    half();
  endtask
  // Released lines show the inverse level
  task automatic release_lines();
    byte_clk_o = 1'b0;
    byte_lines_o = ~byte_lines_o;
    half();
  endtask
  task automatic close_frame(input logic mode3);
    ser_clk_o = mode3;
    byte_clk_o = 1'b0;
    half();
    sel_n_o = 1'b1;
    ser_in_o = ~ser_in_o;
    half();
  endtask
endmodule // fcap_host_model

// ===== bench/test_flash_cmd_address_powerup.sv
// Self-checking bench for the flash command framing front end
`timescale 1ns/100ps
module test_flash_cmd_address_powerup;
  localparam int PUW = 100;
  localparam logic [23:0] ADR = 24'habcdef;
  localparam logic [7:0] OPS [8] = '{8'h0b, 8'hd2, 8'he8, 8'hd4, 8'hd6, 8'h86, 8'h87, 8'hd7};
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic busy = 1'b0;
  logic ce = 1'b1;
  logic sel_n, ser_clk, ser_in, byte_clk, ser_out, ser_oe, byte_oe;
  logic cmd_valid, data_valid, mode3, byte_if, standby, wr_ready;
  logic [7:0] host_lines, byte_o, byte_in, opcode, data, last_data;
  logic [12:0] page;
  logic [10:0] badr;
  logic [4:0] dummy;
  int errors = 0;
  int checks = 0;
  int cmd_cnt = 0;
  int data_cnt = 0;
  always #4 clk = ~clk;
  // Wire level of the shared byte lines
  assign byte_in = byte_oe ? byte_o : host_lines;
  fcap_host_model u_host (.clk_i(clk), .sel_n_o(sel_n), .ser_clk_o(ser_clk),
    .ser_in_o(ser_in), .byte_clk_o(byte_clk), .byte_lines_o(host_lines));
  fcap_top #(.PUW_CYCLES(PUW)) i_dut (.REF_CLK_I(clk), .RESETN_I(resetn), .CE_I(ce),
    .SEL_N_I(sel_n), .SER_CLK_I(ser_clk), .SER_IN_I(ser_in), .SER_OUT_O(ser_out),
    .SER_OUT_OE_O(ser_oe), .BYTE_CLK_I(byte_clk), .BYTE_PORT_LINES_I(byte_in),
    .BYTE_PORT_LINES_O(byte_o), .BYTE_PORT_LINES_OE_O(byte_oe), .CORE_BUSY_I(busy),
    .CMD_VALID_O(cmd_valid), .CMD_OPCODE_O(opcode), .CMD_PAGE_O(page), .CMD_BYTE_O(badr),
    .CMD_DUMMY_O(dummy), .DATA_VALID_O(data_valid), .DATA_O(data), .CLK_MODE3_O(mode3),
    .BYTE_IF_O(byte_if), .STANDBY_O(standby), .WRITE_READY_O(wr_ready));
  always @(posedge clk)
  begin
    if (cmd_valid === 1'b1)
      cmd_cnt <= cmd_cnt + 1;
    if (data_valid === 1'b1)
    begin
      data_cnt <= data_cnt + 1;
      last_data <= data;
    end
  end
  task automatic cmp_vec(input logic [23:0] got, input logic [23:0] exp);
    checks++;
    if (got !== exp)
    begin
      errors++;
      $display("CHECK FAILED at %0t: got %0h, expected %0h", $time, got, exp);
    end
  endtask
  task automatic cmp_bit(input logic got, input logic exp);
    checks++;
    if (got !== exp)
    begin
      errors++;
      $display("CHECK FAILED at %0t: got %0h, expected %0h", $time, got, exp);
    end
  endtask
  function automatic logic [4:0] exp_dummy(input logic [7:0] op, input logic bw);
    case (op)
      8'hd2, 8'he8: exp_dummy = bw ? 5'h13 : 5'h04;
      8'hd4, 8'hd6, 8'h0b: exp_dummy = 5'h01;
      8'hd7: exp_dummy = bw ? 5'h02 : 5'h00;
      default: exp_dummy = 5'h00;
    endcase
  endfunction
  task automatic send_cmd(input logic [7:0] op, input logic m3, input logic bw);
    logic [31:0] fr;
    fr = {op, ADR};
    u_host.open_frame(m3);
    for (int i = 0; i < 4; i++)
    begin
      if (i > 0 && op == 8'hd7)
        break;
      if (bw)
        u_host.par_byte(fr[31 - 8 * i -: 8]);
      else
        u_host.ser_byte(fr[31 - 8 * i -: 8]);
    end
  endtask
  task automatic t_power();
    cmp_bit(mode3, 1'b1);
    cmp_bit(ser_oe | byte_oe, 1'b0);
    cmp_bit(standby, 1'b1);
    repeat (PUW - 10) @(negedge clk);
    cmp_bit(wr_ready, 1'b0);
    repeat (20) @(negedge clk);
    cmp_bit(wr_ready, 1'b1);
  endtask
  task automatic t_header(input logic [7:0] op, input logic m3, input logic bw);
    int n0;
    n0 = cmd_cnt;
    send_cmd(op, m3, bw);
    cmp_vec(24'(cmd_cnt), 24'(n0 + 1));
    cmp_vec(24'(opcode), 24'(op));
    cmp_bit(mode3, m3);
    cmp_bit(byte_if, bw);
    cmp_vec(24'(dummy), 24'(exp_dummy(op, bw)));
    if (op != 8'hd7)
    begin
      cmp_vec(24'(page), (op inside {8'h87, 8'hd4, 8'hd6}) ? 24'h0 : 24'(ADR[23:11]));
      cmp_vec(24'(badr), op == 8'h86 ? 24'h0 : 24'(ADR[10:0]));
    end
    u_host.close_frame(m3);
  endtask
  task automatic t_data();
    int n0;
    n0 = data_cnt;
    send_cmd(8'h0b, 1'b0, 1'b0);
    u_host.ser_byte(8'hff);
    u_host.ser_byte(8'h3c);
    u_host.half();
    cmp_vec(24'(data_cnt), 24'(n0 + 1));
    cmp_vec(24'(last_data), 24'h3c);
    u_host.close_frame(1'b0);
  endtask
  task automatic t_status(input logic bw);
    for (int b = 0; b < 2; b++)
    begin
      busy = b[0];
      send_cmd(8'hd7, 1'b1, bw);
      if (bw)
      begin
        u_host.par_byte(8'h00);
        u_host.par_byte(8'h00);
        u_host.release_lines();
        cmp_bit(byte_oe, 1'b1);
        cmp_vec(24'(byte_in), 24'({~busy, 7'h00}));
      end
      else
      begin
        u_host.ser_low();
        cmp_bit(ser_oe, 1'b1);
        cmp_bit(ser_out, ~busy);
      end
      u_host.close_frame(1'b1);
      cmp_bit(ser_oe | byte_oe, 1'b0);
    end
  endtask
  task automatic t_reset_ignore();
    int n0;
    n0 = cmd_cnt;
    resetn = 1'b0;
    send_cmd(8'h0b, 1'b0, 1'b0);
    resetn = 1'b1;
    send_cmd(8'h0b, 1'b0, 1'b0);
    cmp_vec(24'(cmd_cnt), 24'(n0));
    cmp_bit(mode3, 1'b1);
    cmp_bit(standby, 1'b1);
    u_host.close_frame(1'b0);
    t_header(8'hd2, 1'b0, 1'b0);
  endtask
  // Clock enable low freezes the frame opening and the mode pick
  task automatic t_freeze();
    ce = 1'b0;
    u_host.open_frame(1'b1);
    cmp_bit(standby, 1'b1);
    cmp_bit(mode3, 1'b0);
    ce = 1'b1;
    u_host.half();
    cmp_bit(standby, 1'b0);
    cmp_bit(mode3, 1'b1);
    u_host.close_frame(1'b1);
  endtask
  task automatic test_done();
    $display("Checks made: %0d, mismatches: %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial
  begin
    repeat (60000) @(posedge clk);
    errors++;
    test_done();
  end
  initial
  begin
    repeat (5) @(negedge clk);
    resetn = 1'b1;
    t_power();
    repeat (6250) @(negedge clk);
    foreach (OPS[i])
      t_header(OPS[i], i[0], 1'b0);
    t_header(8'hd2, 1'b1, 1'b1);
    t_header(8'he8, 1'b0, 1'b1);
    t_header(8'hd7, 1'b1, 1'b1);
    t_status(1'b0);
    t_status(1'b1);
    t_data();
    t_reset_ignore();
    t_freeze();
    test_done();
  end
endmodule // test_flash_cmd_address_powerup
